// ### frw_chk_assertions.sv
`timescale 1ns/1ps
module frw_chk #(parameter int TW_CYCLES = 20)
(
  // design ports
  input wire clock_i,
  input wire nrst_i,
  input wire [23:0] addr24_i,
  input wire [31:0] addr32_i,
  input wire [31:0] array_addr_o,
  input wire [15:0] status_o,
  input wire [7:0] config_o,
  input wire [7:0] extended_address_byte_o,
  input wire current_addr_mode_o,
  input wire write_in_progress_o,
  input wire write_enable_latch_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  int n;
  always @(posedge clock_i) n <= (!nrst_i || !write_in_progress_o) ? 0 : n + 1;
  sequence s_go; $rose(write_in_progress_o); endsequence
  sequence s_end; $fell(write_in_progress_o); endsequence
  sequence s_calm; $stable({addr24_i, addr32_i, extended_address_byte_o, current_addr_mode_o}) [*3]; endsequence
  AST_GO_WEL: assert property (s_go |-> write_enable_latch_o) else $error("busy without latch");
  AST_TW_LEN: assert property (s_end |-> n >= TW_CYCLES - 1 && n <= TW_CYCLES + 1) else $error("busy length");
  AST_WEL_CLR: assert property (s_end |-> ##[0:1] !write_enable_latch_o) else $error("latch kept");
  AST_KEEP: assert property ($stable({status_o[15], status_o[10]})) else $error("fixed bits moved");
  AST_RSV: assert property (extended_address_byte_o[6:2] == 5'h00) else $error("reserved set");
  AST_ADDR3: assert property (s_calm ##0 !current_addr_mode_o |->
    array_addr_o == {6'h00, extended_address_byte_o[1:0], addr24_i}) else $error("addr3");
  AST_ADDR4: assert property (s_calm ##0 current_addr_mode_o |-> array_addr_o == addr32_i) else $error("addr4");
  AST_MODE: assert property (current_addr_mode_o == config_o[0]) else $error("mode bit");
endmodule // frw_chk
bind frw_core frw_chk #(.TW_CYCLES(TW_CYCLES)) u_frw_chk (.clock_i(clock_i), .nrst_i(nrst_i),
  .addr24_i(addr24_i), .addr32_i(addr32_i), .array_addr_o(array_addr_o), .status_o(status_o),
  .config_o(config_o), .extended_address_byte_o(extended_address_byte_o),
  .current_addr_mode_o(current_addr_mode_o), .write_in_progress_o(write_in_progress_o),
  .write_enable_latch_o(write_enable_latch_o));

// ### frw_core.v
`timescale 1ns/1ps
`include "frw_regs.vh"
module frw_core #(
  parameter [31:0] TW_CYCLES = `FRW_WRITE_CYCLE_CLKS
) (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // serial link pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o,
  // read path hooks
  input wire [23:0] addr24_i,
  input wire [31:0] addr32_i,
  input wire dummy_phase_i,
  input wire [2:0] dummy_bit_i,
  output reg [31:0] array_addr_o,
  output reg learn_oe_o,
  output reg learn_bit_o,
  // register state
  output reg [15:0] status_o,
  output reg [7:0] config_o,
  output reg [7:0] extended_address_byte_o,
  output reg current_addr_mode_o,
  output reg write_in_progress_o,
  output reg write_enable_latch_o
);
  localparam [7:0] LEARN_PATTERN = `FRW_LEARN_PATTERN;
  // pin synchronisers, only the second stage feeds logic
  reg [1:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] si_s;
  reg [1:0] wp_s;
  reg sclk_d;
  reg cs_d;
  // register file
  reg [15:0] status;
  reg [7:0] config_r;
  reg [7:0] ext_addr;
  // command shifter
  reg [7:0] opcode;
  reg [7:0] shreg;
  reg [15:0] data16;
  reg [5:0] bitcnt;
  // self-timed write cycle
  reg [31:0] tw_cnt;
  reg write_in_progress;
  reg write_enable_latch;
  reg mode4;
  // read shifter
  reg out_act;
  reg [2:0] out_idx;
  reg [7:0] out_byte;
  // link events and command decode
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;
  wire hw_protect;
  wire [7:0] next_shreg;
  wire [15:0] sr_one_byte;
  wire [15:0] sr_wr;
  wire [15:0] next_status;
  wire frame_opcode_only;
  wire frame_one_byte;
  wire frame_two_byte;
  wire exec_status;
  wire exec_config;
  wire exec_ext;

  function is_status_write;
    input [7:0] op;
    begin
      is_status_write = (op == `FRW_OP_WR_STATUS) || (op == `FRW_OP_WR_STATUS_ALT);
    end
  endfunction

  function is_read_op;
    input [7:0] op;
    begin
      is_read_op = (op == `FRW_OP_RD_STATUS0) || (op == `FRW_OP_RD_STATUS1)
                   || (op == `FRW_OP_RD_CONFIG) || (op == `FRW_OP_RD_EXT);
    end
  endfunction

  function [7:0] rd_byte;
    input [7:0] op;
    begin
      case (op)
        `FRW_OP_RD_STATUS0: rd_byte = {status[7:2], write_enable_latch, write_in_progress}; // [R6]
        `FRW_OP_RD_STATUS1: rd_byte = status[15:8];
        `FRW_OP_RD_CONFIG: rd_byte = {config_r[7:1], mode4}; // [R19]
        `FRW_OP_RD_EXT: rd_byte = ext_addr; // [R12]
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;
  assign cs_fall = ~cs_s[1] & cs_d;
  assign cs_rise = cs_s[1] & ~cs_d;
  // a set upper protect bit locks until reset, whatever the pin says
  assign hw_protect = ((status[`FRW_SR_PROT_HI_BIT:`FRW_SR_PROT_LO_BIT] == 2'b01) && !wp_s[1])
                      || status[`FRW_SR_PROT_HI_BIT]; // [R9]
  assign next_shreg = {shreg[6:0], si_s[1]};
  assign frame_opcode_only = (bitcnt == `FRW_BITS_OPCODE);
  assign frame_one_byte = (bitcnt == `FRW_BITS_ONE_BYTE);
  assign frame_two_byte = (bitcnt == `FRW_BITS_TWO_BYTE);
  assign sr_one_byte = {status[15:8], data16[7:0]}; // [R4]
  assign sr_wr = frame_two_byte ? data16 : sr_one_byte;
  assign next_status = (status & `FRW_SR_KEEP_MASK) | (sr_wr & ~`FRW_SR_KEEP_MASK); // [R2] [R8]
  assign exec_status = is_status_write(opcode) && write_enable_latch && !hw_protect
                       && (frame_one_byte || frame_two_byte); // [R1] [R3] [R9]
  assign exec_config = (opcode == `FRW_OP_WR_CONFIG) && write_enable_latch && frame_one_byte; // [R10]
  assign exec_ext = (opcode == `FRW_OP_WR_EXT) && write_enable_latch && frame_one_byte; // [R16]

  // pins cross into the clock domain through two flops
  always @(posedge clock_i)
  begin
    sclk_s <= {sclk_s[0], sclk_i};
    cs_s <= {cs_s[0], cs_n_i};
    si_s <= {si_s[0], si_i};
    wp_s <= {wp_s[0], wp_n_i};
  end

  // edge memories reset to the idle pin levels, so no false edge after reset
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end

  // opcode and data bytes, msb first on rising link clock
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      opcode <= 8'h00;
      shreg <= 8'h00;
      data16 <= 16'h0000;
      bitcnt <= 6'd0;
    end
    else if (cs_fall)
    begin
      bitcnt <= 6'd0;
    end
    else if (!cs_s[1] && sclk_rise)
    begin
      shreg <= next_shreg;
      // count saturates so a long frame never wraps onto a legal boundary
      if (bitcnt < `FRW_BITS_MAX)
      begin
        bitcnt <= bitcnt + 6'd1;
      end
      if (bitcnt == `FRW_BITS_OPCODE - 6'd1)
      begin
        opcode <= next_shreg;
      end
      else if (bitcnt >= `FRW_BITS_OPCODE && bitcnt < `FRW_BITS_ONE_BYTE)
      begin
        data16 <= {8'h00, next_shreg};
      end
      else if (bitcnt >= `FRW_BITS_ONE_BYTE && bitcnt < `FRW_BITS_TWO_BYTE)
      begin
        // second byte goes to the upper status half
        data16 <= {next_shreg, data16[7:0]};
      end
    end
  end

  // read answers on falling link clock
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      out_act <= 1'b0;
      out_idx <= 3'd0;
      out_byte <= 8'h00;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else if (cs_fall || cs_rise)
    begin
      out_act <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else if (!cs_s[1] && sclk_rise && bitcnt == `FRW_BITS_OPCODE - 6'd1)
    begin
      out_byte <= rd_byte(next_shreg);
      out_act <= is_read_op(next_shreg);
      out_idx <= 3'd7;
    end
    else if (!cs_s[1] && sclk_fall && out_act)
    begin
      so_oe_o <= 1'b1;
      so_o <= out_byte[out_idx]; // [R12]
      out_idx <= out_idx - 3'd1;
      if (out_idx == 3'd0)
      begin
        // refetch so a polled busy flag is fresh on every byte
        out_byte <= rd_byte(opcode); // [R6]
      end
    end
  end

  // register file and the self-timed write cycle
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      status <= `FRW_SR_RESET;
      config_r <= `FRW_CR_RESET;
      ext_addr <= `FRW_EXT_RESET; // [R17]
      tw_cnt <= 32'd0;
      write_in_progress <= 1'b0;
      write_enable_latch <= 1'b0;
      mode4 <= 1'b0;
    end
    else
    begin
      if (write_in_progress)
      begin
        if (tw_cnt <= 32'd1)
        begin
          write_in_progress <= 1'b0; // [R5] [R11]
          write_enable_latch <= 1'b0; // [R7] [R11]
        end
        tw_cnt <= tw_cnt - 32'd1;
      end
      // a busy device ignores every command that could change state
      if (cs_rise && !write_in_progress)
      begin
        if (frame_opcode_only && opcode == `FRW_OP_WR_ENABLE)
        begin
          write_enable_latch <= 1'b1;
        end
        else if (frame_opcode_only && opcode == `FRW_OP_WR_DISABLE)
        begin
          write_enable_latch <= 1'b0;
        end
        else if (frame_opcode_only && opcode == `FRW_OP_ENTER_4B)
        begin
          mode4 <= 1'b1; // [R18] [R20]
        end
        else if (frame_opcode_only && opcode == `FRW_OP_EXIT_4B)
        begin
          mode4 <= 1'b0;
        end
        else if (exec_status) // [R1] [R3] [R9]
        begin
          status <= next_status;
          write_in_progress <= 1'b1; // [R5]
          tw_cnt <= TW_CYCLES;
        end
        else if (exec_config) // [R10]
        begin
          // mode bit is read only and lives in mode4
          config_r <= {data16[7:1], config_r[0]};
          write_in_progress <= 1'b1; // [R11]
          tw_cnt <= TW_CYCLES;
        end
        else if (exec_ext) // [R16]
        begin
          // volatile register needs no timed cycle, latch is spent at once
          ext_addr <= data16[7:0] & `FRW_EXT_MASK;
          write_enable_latch <= 1'b0;
        end
      end
    end
  end

  // outputs are registered copies, one clock behind the state
  always @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      array_addr_o <= 32'h00000000;
      learn_oe_o <= 1'b0;
      learn_bit_o <= 1'b0;
      status_o <= 16'h0000;
      config_o <= 8'h00;
      extended_address_byte_o <= 8'h00;
      current_addr_mode_o <= 1'b0;
      write_in_progress_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
    end
    else
    begin
      // upper segment only reaches the array in 3-byte mode
      array_addr_o <= mode4 ? addr32_i : {6'h00, ext_addr[1:0], addr24_i}; // [R13] [R14]
      learn_oe_o <= dummy_phase_i && ext_addr[`FRW_EXT_LEARN_BIT]; // [R15]
      learn_bit_o <= dummy_phase_i && ext_addr[`FRW_EXT_LEARN_BIT] && LEARN_PATTERN[3'd7 - dummy_bit_i]; // [R15]
      status_o <= {status[15:2], write_enable_latch, write_in_progress};
      config_o <= {config_r[7:1], mode4};
      extended_address_byte_o <= ext_addr;
      current_addr_mode_o <= mode4; // [R19]
      write_in_progress_o <= write_in_progress;
      write_enable_latch_o <= write_enable_latch;
    end
  end
endmodule // frw_core

// ### frw_host.sv
`timescale 1ns/1ps
module frw_host (
  // clock
  input wire clock_i,
  // serial link
  input wire so_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  initial {sclk_o, cs_n_o, si_o} = 3'b010;
  task automatic half(input logic s);
    repeat (4) @(posedge clock_i);
    #1 sclk_o = s;
  endtask
  // cs rises only after whole bits, msb first
  task automatic xfer(input logic [23:0] v, input int nb, output logic [7:0] rd);
    @(posedge clock_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      si_o = v[23 - i];
      half(1'b1);
      rd = {rd[6:0], so_i};
      half(1'b0);
    end
    // released line must not keep its last level
    si_o = ~si_o;
    half(1'b0);
    cs_n_o = 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
endmodule // frw_host

// ### frw_regs.vh
// Behaviour
// R1: status write accepted only while write enable latch is set
// R2: status write never changes status bits 15, 10, 1 and 0
// R3: status write executes only if chip select rises after 8 or 16 data bits
// R4: one-byte status write keeps status bits 15 to 8 unchanged
// R5: accepted status write runs timed cycle with write-in-progress held high
// R6: status register reads still answered during the timed cycle
// R7: write enable latch cleared when the timed cycle ends
// R8: block-protect and status-protect bits updated, gated by write-protect pin
// R9: hardware protected mode makes every status write ignored
// R10: config write needs write enable latch and exactly 8 data bits
// R11: accepted config write runs timed cycle, then clears write enable latch
// R12: extended address read shifts register out msb first on falling edges
// R13: in 3-byte mode the extended register supplies address bits 31 to 24; code takes only bits 25 to 24 from it, bits 31 to 26 are 0
// R14: in 4-byte mode four address bytes used, segment bits ignored
// R15: learning-pattern bit drives 00110100 during read dummy cycles
// R16: extended address write accepted only while write enable latch is set
// R17: extended address register clears at power up and reset
// R18: enter 4-byte mode opcode alone switches to 32-bit addressing
// R19: current address mode bit reads 0 in 3-byte, 1 in 4-byte mode
// R20: enter 4-byte mode command sets current address mode indication
`ifndef FRW_REGS_VH
`define FRW_REGS_VH
`define FRW_OP_WR_ENABLE 8'h06
`define FRW_OP_WR_DISABLE 8'h04
`define FRW_OP_RD_STATUS0 8'h05
`define FRW_OP_RD_STATUS1 8'h35
`define FRW_OP_WR_STATUS 8'h01
`define FRW_OP_WR_STATUS_ALT 8'h31
`define FRW_OP_RD_CONFIG 8'h15
`define FRW_OP_WR_CONFIG 8'h11
`define FRW_OP_RD_EXT 8'hc8
`define FRW_OP_WR_EXT 8'hc5
`define FRW_OP_ENTER_4B 8'hb7
`define FRW_OP_EXIT_4B 8'he9
`define FRW_SR_KEEP_MASK 16'h8403
`define FRW_SR_RESET 16'h0000
`define FRW_CR_RESET 8'h00
`define FRW_EXT_RESET 8'h00
`define FRW_EXT_MASK 8'h83
`define FRW_LEARN_PATTERN 8'h34
`define FRW_SR_BUSY_BIT 0
`define FRW_SR_LATCH_BIT 1
`define FRW_SR_PROT_LO_BIT 7
`define FRW_SR_PROT_HI_BIT 8
`define FRW_EXT_LEARN_BIT 7
`define FRW_CR_MODE_BIT 0
`define FRW_BITS_OPCODE 6'd8
`define FRW_BITS_ONE_BYTE 6'd16
`define FRW_BITS_TWO_BYTE 6'd24
`define FRW_BITS_MAX 6'd40
`define FRW_WRITE_CYCLE_NS 32'd10000
`define FRW_CLK_MHZ 32'd50
`define FRW_WRITE_CYCLE_CLKS ((`FRW_WRITE_CYCLE_NS * `FRW_CLK_MHZ) / 32'd1000)
`endif

// ### test_flash_register_write_addr_mode.sv
`timescale 1ns/1ps
module test_flash_register_write_addr_mode;
  logic clock_i = 0, nrst_i = 0, wp_n_i = 1, dummy_phase_i = 0;
  logic [2:0] dummy_bit_i = 0;
  logic [23:0] addr24_i = 0;
  logic [31:0] addr32_i = 0;
  wire sclk, cs_n, si, so_o, so_oe_o, learn_oe_o, learn_bit_o;
  wire current_addr_mode_o, write_in_progress_o, write_enable_latch_o;
  wire [31:0] array_addr_o;
  wire [15:0] status_o;
  wire [7:0] config_o, extended_address_byte_o;
  logic [7:0] rd, lf = 8'h34, pat = 8'b00110100;
  logic [31:0] exp_q[$], obs_q[$];
  string nm_q[$];
  int err_total = 0, samples_checked = 0, cyc = 0;
  frw_core #(.TW_CYCLES(20)) u_frw_core (.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .addr24_i(addr24_i), .addr32_i(addr32_i),
    .dummy_phase_i(dummy_phase_i), .dummy_bit_i(dummy_bit_i), .array_addr_o(array_addr_o),
    .learn_oe_o(learn_oe_o), .learn_bit_o(learn_bit_o), .status_o(status_o), .config_o(config_o),
    .extended_address_byte_o(extended_address_byte_o), .current_addr_mode_o(current_addr_mode_o),
    .write_in_progress_o(write_in_progress_o), .write_enable_latch_o(write_enable_latch_o));
  frw_host u_frw_host (.clock_i(clock_i), .so_i(so_o), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tally_and_finish;
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic note(input string n, input logic [31:0] e, input logic [31:0] s);
    nm_q.push_back(n);
    exp_q.push_back(e);
    obs_q.push_back(s);
  endtask
  // bounded wait for the timed write to end
  task automatic cmd(input logic [23:0] v, input int nb);
    u_frw_host.xfer(v, nb, rd);
    for (int k = 0; k < 80 && write_in_progress_o !== 1'b0; k++) @(posedge clock_i);
    #1;
  endtask
  task automatic check_val(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  initial forever #10 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
    if (obs_q.size() > 0)
    begin
      check_val(nm_q[0], obs_q[0], exp_q[0]);
      void'(obs_q.pop_front());
      void'(exp_q.pop_front());
      void'(nm_q.pop_front());
    end
  end
  initial
  begin
    repeat (20) @(posedge clock_i);
    #1 nrst_i = 1;
    repeat (4) @(posedge clock_i);
    #1 note("ear", 8'h00, extended_address_byte_o);
    cmd(24'h01ff00, 16);
    note("sr", 16'h0000, status_o);
    cmd(24'h060000, 8);
    cmd(24'h013c44, 24);
    note("sr", 16'h403c, status_o);
    cmd(24'h060000, 8);
    cmd(24'h01a000, 12);
    note("sr", 16'h403e, status_o);
    cmd(24'h010800, 16);
    note("sr", 16'h4008, status_o);
    lf = nxt(lf);
    cmd(24'h060000, 8);
    cmd({8'h11, lf, 8'h00}, 16);
    cmd({8'h11, ~lf, 8'h00}, 16);
    note("cr", {lf[7:1], 1'b0}, config_o);
    repeat (3)
    begin
      lf = nxt(lf);
      addr24_i = {3{lf}};
      cmd(24'h060000, 8);
      cmd({8'hc5, lf, 8'h00}, 16);
      note("ear", lf & 8'h83, extended_address_byte_o);
      cmd(24'hc80000, 16);
      note("ext_addr_read_cmd", lf & 8'h83, rd);
      note("addr", {6'h00, lf[1:0], addr24_i}, array_addr_o);
      dummy_phase_i = 1;
      for (int b = 0; b < 8; b++)
      begin
        dummy_bit_i = b;
        repeat (4) @(posedge clock_i);
        #1 note("learn", {lf[7], lf[7] & pat[7 - b]}, {learn_oe_o, learn_bit_o});
      end
      dummy_phase_i = 0;
    end
    addr32_i = {lf, lf, 16'h1234};
    cmd(24'hb70000, 8);
    note("mode", 1, current_addr_mode_o);
    note("addr", addr32_i, array_addr_o);
    wp_n_i = 0;
    cmd(24'h060000, 8);
    cmd(24'h018000, 16);
    cmd(24'h060000, 8);
    cmd(24'h010000, 16);
    note("sr", 16'h4082, status_o);
    repeat (4) @(posedge clock_i);
    tally_and_finish();
  end
endmodule // test_flash_register_write_addr_mode
